// *** omir_pkg.sv ***
// shared constants and types for the optical motion image readout
package omir_pkg;

    // ------------------------------------------------------------
    // register offsets on the serial port
    // ------------------------------------------------------------
    localparam logic [6:0] OMIR_ADDR_HORIZ = 7'h03;
    localparam logic [6:0] OMIR_ADDR_VERT = 7'h04;
    localparam logic [6:0] OMIR_ADDR_QUALITY = 7'h05;
    localparam logic [6:0] OMIR_ADDR_EXP_HIGH = 7'h06;
    localparam logic [6:0] OMIR_ADDR_EXP_LOW = 7'h07;
    localparam logic [6:0] OMIR_ADDR_PEAK = 7'h08;
    localparam logic [6:0] OMIR_ADDR_SUM = 7'h09;
    localparam logic [6:0] OMIR_ADDR_LOWEST = 7'h0A;
    localparam logic [6:0] OMIR_ADDR_CAPTURE = 7'h0B;
    localparam logic [6:0] OMIR_ADDR_UPPER = 7'h0C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] OMIR_RST_EXPOSURE = 16'h0064;
    localparam logic [7:0] OMIR_RST_PEAK = 8'hD0;
    localparam logic [7:0] OMIR_RST_SUM = 8'h80;
    localparam logic [7:0] OMIR_RST_ZERO = 8'h00;

    // ------------------------------------------------------------
    // field layout and limits
    // ------------------------------------------------------------
    localparam int OMIR_CMD_WRITE_BIT = 7;
    localparam int OMIR_SUM_LSB = 9;
    localparam int OMIR_UPPER_X_LSB = 4;
    localparam logic [8:0] OMIR_FEATURE_MAX = 9'h168;
    localparam logic [7:0] OMIR_PIXEL_MAX = 8'hFE;
    localparam logic [16:0] OMIR_SUM_MAX = 17'h1E038;
    localparam logic [8:0] OMIR_GRAB_LAST = 9'h1E3;
    localparam logic [11:0] OMIR_WIDE_POS = 12'h7FF;
    localparam logic [11:0] OMIR_WIDE_NEG = 12'h800;
    localparam logic [11:0] OMIR_NARROW_POS = 12'h07F;
    localparam logic [11:0] OMIR_NARROW_NEG = 12'hF80;
    localparam logic [2:0] OMIR_RES_FULL = 3'h3;

    // ------------------------------------------------------------
    // exposure control limits
    // ------------------------------------------------------------
    localparam logic [7:0] OMIR_EXP_PEAK_HIGH = 8'hF0;
    localparam logic [7:0] OMIR_EXP_PEAK_LOW = 8'h96;
    localparam logic [15:0] OMIR_EXP_MIN = 16'h0001;
    localparam logic [15:0] OMIR_EXP_MAX = 16'hFFFF;
    localparam int OMIR_EXP_STEP_SHIFT = 4;

    // ------------------------------------------------------------
    // buffering
    // ------------------------------------------------------------
    localparam int OMIR_FIFO_DEPTH = 8;

    // one pixel of the frame stream, delivered in pixel index order
    typedef struct packed {
        logic last;
        logic feature;
        logic [7:0] value;
    } omir_pixel_t;

    localparam int OMIR_PIXEL_W = $bits(omir_pixel_t);

    // one motion sample from the correlator
    typedef struct packed {
        logic [11:0] dx;
        logic [11:0] dy;
    } omir_motion_t;

endpackage

// *** omir_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps

module omir_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic ready;
    } omir_fifo_state_t;

    omir_fifo_state_t st;
    omir_fifo_state_t next_st;
    logic push;
    logic pop;

    // ready is registered so the source sees a clean flop
    assign in_ready = st.ready;
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rd_ptr];
    assign push = in_valid && st.ready;
    assign pop = out_valid && out_ready;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr = (st.wr_ptr == LAST_PTR) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == LAST_PTR) ? '0 : st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        next_st.ready = (next_st.count != FULL_CNT);
    end

    // storage itself needs no reset, only the pointers, count and ready flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st.mem <= st.mem;
            st.wr_ptr <= '0;
            st.rd_ptr <= '0;
            st.count <= '0;
            st.ready <= 1'b0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** omir_readout.sv ***
// measurement registers of the motion sensor behind its four-wire serial port
`timescale 1ns/1ps

// Functional notes
// (R01) separate 8-bit signed x and y counts
// (R02) reading a count returns it, then clears
// (R03) count scale follows selected resolution
// (R04) controller reads x, y, upper bits consecutively
// (R05) quality shows upper 8 of 9-bit features
// (R06) quality never above 180
// (R07) exposure is 16-bit cycles, two byte registers
// (R08) controller reads exposure high then low
// (R09) exposure adjusts automatically to pixel levels
// (R10) peak pixel of frame, 0 to 254
// (R11) lowest pixel of frame, 0 to 254
// (R12) 17-bit pixel sum, bits 16:9 shown
// (R13) sum capped 122936, register at most 240
// (R14) grabber takes one pixel per frame
// (R15) top bit flags 7-bit pixel valid
// (R16) 484 grabber reads cover 22x22 image
// (R17) any capture register write resets index
// (R18) indices run down columns, last is 483
// (R19) valid read advances index, clears flag
// (R20) wide mode joins upper nibble above byte
// (R21) registers reached only via serial port
module omir_readout (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic spi_ncs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire omir_pkg::omir_pixel_t pixel_in,
    input wire logic pixel_in_valid,
    output logic pixel_in_ready,
    input wire omir_pkg::omir_motion_t motion_in,
    input wire logic motion_valid,
    input wire logic [2:0] resolution_sel,
    input wire logic wide_motion,
    output logic [15:0] exposure_time
);
    import omir_pkg::*;

    typedef struct packed {
        logic sclk_q;
        logic [2:0] bit_cnt;
        logic data_phase;
        logic is_write;
        logic [6:0] addr;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic miso;
        logic [11:0] acc_x;
        logic [11:0] acc_y;
        logic [3:0] upper_x;
        logic [3:0] upper_y;
        logic [8:0] feat_cnt;
        logic [7:0] peak_cur;
        logic [7:0] low_cur;
        logic [16:0] sum_cur;
        logic [7:0] quality;
        logic [7:0] peak;
        logic [7:0] lowest;
        logic [7:0] sum_upper;
        logic [15:0] exposure;
        logic [7:0] exp_low_hold;
        logic exp_locked;
        logic [8:0] frame_idx;
        logic [8:0] grab_idx;
        logic [6:0] grab_value;
        logic grab_valid;
    } omir_state_t;

    omir_state_t st;
    omir_state_t next_st;
    omir_pixel_t fifo_out;
    logic fifo_valid;
    logic fifo_ready;
    logic sclk_rise;
    logic sclk_fall;
    logic addr_done;
    logic data_done;
    logic reg_read;
    logic reg_write;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // scale a full-resolution delta down to the selected resolution
    function automatic logic [11:0] scale_delta(input logic [11:0] raw, input logic [2:0] res);
        logic [2:0] drop;
        drop = (res >= OMIR_RES_FULL) ? 3'h0 : OMIR_RES_FULL - res;
        return 12'($signed(raw) >>> drop);
    endfunction

    // saturating signed add, clipped to the active reporting width
    function automatic logic [11:0] sat_add(input logic [11:0] acc, input logic [11:0] d, input logic wide);
        logic signed [12:0] sum;
        logic signed [12:0] hi;
        logic signed [12:0] lo;
        sum = $signed({acc[11], acc}) + $signed({d[11], d});
        hi = wide ? $signed({1'b0, OMIR_WIDE_POS}) : $signed({1'b0, OMIR_NARROW_POS});
        lo = wide ? $signed({1'b1, OMIR_WIDE_NEG}) : $signed({1'b1, OMIR_NARROW_NEG});
        if (sum > hi) begin
            sum = hi;
        end else if (sum < lo) begin
            sum = lo;
        end
        return sum[11:0];
    endfunction

    // clip a raw pixel into the reportable range
    function automatic logic [7:0] clip_pixel(input logic [7:0] v);
        return (v > OMIR_PIXEL_MAX) ? OMIR_PIXEL_MAX : v;
    endfunction

    // register read mux
    function automatic logic [7:0] read_value(input omir_state_t s, input logic [6:0] a);
        logic [7:0] v;
        v = OMIR_RST_ZERO;
        unique case (a)
            OMIR_ADDR_HORIZ: v = s.acc_x[7:0];
            OMIR_ADDR_VERT: v = s.acc_y[7:0];
            OMIR_ADDR_QUALITY: v = s.quality;
            OMIR_ADDR_EXP_HIGH: v = s.exposure[15:8];
            OMIR_ADDR_EXP_LOW: v = s.exp_low_hold;
            OMIR_ADDR_PEAK: v = s.peak;
            OMIR_ADDR_SUM: v = s.sum_upper;
            OMIR_ADDR_LOWEST: v = s.lowest;
            OMIR_ADDR_CAPTURE: v = {s.grab_valid, s.grab_value};
            OMIR_ADDR_UPPER: v = {s.upper_x, s.upper_y};
            default: v = OMIR_RST_ZERO;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // pixel buffer
    // ------------------------------------------------------------

    // pixel intake pauses for one cycle on each register access so reads see settled stats
    assign fifo_ready = !(reg_read || reg_write);

    omir_fifo #(
        .WIDTH(OMIR_PIXEL_W),
        .DEPTH(OMIR_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_data(pixel_in),
        .in_valid(pixel_in_valid),
        .in_ready(pixel_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready)
    );

    // ------------------------------------------------------------
    // serial port decode
    // ------------------------------------------------------------

    // sclk idles high; data is sampled on the rising edge, driven on the falling edge
    assign sclk_rise = !spi_ncs_n && spi_sclk && !st.sclk_q;
    assign sclk_fall = !spi_ncs_n && !spi_sclk && st.sclk_q;
    assign addr_done = sclk_rise && !st.data_phase && (st.bit_cnt == 3'h7);
    assign data_done = sclk_rise && st.data_phase && (st.bit_cnt == 3'h7);
    assign reg_read = addr_done && !st.shift_in[OMIR_CMD_WRITE_BIT - 1]; // R21
    assign reg_write = data_done && st.is_write; // R21

    assign spi_miso = st.miso;
    assign exposure_time = st.exposure;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] rd_addr;
        logic [11:0] dx;
        logic [11:0] dy;
        logic [7:0] pix;
        logic [7:0] peak_fin;
        logic [7:0] low_fin;
        logic [16:0] sum_fin;
        logic [8:0] feat_fin;
        logic [15:0] step;
        logic pop;
        rd_addr = {st.shift_in[5:0], spi_mosi};
        dx = scale_delta(motion_in.dx, resolution_sel); // R03
        dy = scale_delta(motion_in.dy, resolution_sel); // R03
        pix = clip_pixel(fifo_out.value);
        pop = fifo_valid && fifo_ready;
        peak_fin = st.peak_cur;
        low_fin = st.low_cur;
        sum_fin = st.sum_cur;
        feat_fin = st.feat_cnt;
        step = '0;
        next_st = st;
        next_st.sclk_q = spi_sclk;

        // serial shifter; chip select high returns the port to idle
        if (spi_ncs_n) begin
            next_st.bit_cnt = '0;
            next_st.data_phase = 1'b0;
            next_st.is_write = 1'b0;
            next_st.miso = 1'b0;
        end else if (sclk_rise) begin
            next_st.shift_in = {st.shift_in[6:0], spi_mosi};
            next_st.bit_cnt = st.bit_cnt + 1'b1;
            if (addr_done) begin
                next_st.data_phase = 1'b1;
                next_st.is_write = st.shift_in[OMIR_CMD_WRITE_BIT - 1];
                next_st.addr = rd_addr;
                next_st.shift_out = read_value(st, rd_addr);
            end else if (data_done) begin
                next_st.data_phase = 1'b0;
            end
        end else if (sclk_fall && st.data_phase) begin
            next_st.miso = st.shift_out[7];
            next_st.shift_out = {st.shift_out[6:0], 1'b0};
        end

        // motion accumulation; a read clears but a same-cycle delta survives
        if (reg_read && rd_addr == OMIR_ADDR_HORIZ) begin
            next_st.upper_x = st.acc_x[11:8]; // R20
            next_st.acc_x = '0; // R02
        end
        if (reg_read && rd_addr == OMIR_ADDR_VERT) begin
            next_st.upper_y = st.acc_y[11:8]; // R20
            next_st.acc_y = '0; // R02
        end
        if (motion_valid) begin
            next_st.acc_x = sat_add(next_st.acc_x, dx, wide_motion); // R01
            next_st.acc_y = sat_add(next_st.acc_y, dy, wide_motion); // R01
        end

        // exposure pair: high read freezes the low byte until it is read
        if (reg_read && rd_addr == OMIR_ADDR_EXP_HIGH) begin
            next_st.exp_locked = 1'b1; // R08
        end else if (reg_read && rd_addr == OMIR_ADDR_EXP_LOW) begin
            next_st.exp_locked = 1'b0;
        end

        // grabber: a valid read moves on to the next pixel
        if (reg_read && rd_addr == OMIR_ADDR_CAPTURE && st.grab_valid) begin
            next_st.grab_valid = 1'b0; // R19
            next_st.grab_idx = (st.grab_idx == OMIR_GRAB_LAST) ? '0 : st.grab_idx + 1'b1; // R16
        end

        // frame statistics from the buffered pixel stream
        if (pop) begin
            peak_fin = (pix > st.peak_cur) ? pix : st.peak_cur; // R10
            low_fin = (pix < st.low_cur) ? pix : st.low_cur; // R11
            sum_fin = (st.sum_cur + 17'(pix) > OMIR_SUM_MAX) ? OMIR_SUM_MAX : st.sum_cur + 17'(pix); // R13
            feat_fin = (fifo_out.feature && st.feat_cnt != OMIR_FEATURE_MAX) ? st.feat_cnt + 1'b1 : st.feat_cnt; // R06
            if (st.frame_idx == st.grab_idx && !st.grab_valid) begin
                next_st.grab_value = fifo_out.value[7:1]; // R14
                next_st.grab_valid = 1'b1; // R15
            end
            if (fifo_out.last) begin
                next_st.peak = peak_fin;
                next_st.lowest = low_fin;
                next_st.sum_upper = sum_fin[16:OMIR_SUM_LSB]; // R12
                next_st.quality = feat_fin[8:1]; // R05
                next_st.peak_cur = '0;
                next_st.low_cur = OMIR_PIXEL_MAX;
                next_st.sum_cur = '0;
                next_st.feat_cnt = '0;
                next_st.frame_idx = '0;
                // nudge exposure by about six percent per frame to avoid hunting
                step = st.exposure >> OMIR_EXP_STEP_SHIFT;
                if (peak_fin > OMIR_EXP_PEAK_HIGH) begin
                    next_st.exposure = (st.exposure - step - 1'b1 < OMIR_EXP_MIN || st.exposure <= step + 1'b1)
                        ? OMIR_EXP_MIN : st.exposure - step - 1'b1; // R09
                end else if (peak_fin < OMIR_EXP_PEAK_LOW) begin
                    next_st.exposure = (OMIR_EXP_MAX - st.exposure <= step + 1'b1)
                        ? OMIR_EXP_MAX : st.exposure + step + 1'b1; // R09
                end
            end else begin
                next_st.peak_cur = peak_fin;
                next_st.low_cur = low_fin;
                next_st.sum_cur = sum_fin;
                next_st.feat_cnt = feat_fin;
                next_st.frame_idx = (st.frame_idx == OMIR_GRAB_LAST) ? st.frame_idx : st.frame_idx + 1'b1; // R18
            end
        end

        // write to the capture register restarts the image from index 0
        if (reg_write && st.addr == OMIR_ADDR_CAPTURE) begin
            next_st.grab_idx = '0; // R17
            next_st.grab_valid = 1'b0; // R17
        end

        // low byte tracks the live exposure unless a pair read is in progress
        if (!next_st.exp_locked) begin
            next_st.exp_low_hold = next_st.exposure[7:0]; // R07
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.sclk_q <= 1'b1;
            st.low_cur <= OMIR_PIXEL_MAX;
            st.peak <= OMIR_RST_PEAK;
            st.sum_upper <= OMIR_RST_SUM;
            st.exposure <= OMIR_RST_EXPOSURE;
            st.exp_low_hold <= OMIR_RST_EXPOSURE[7:0];
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** omir_readout_chk.sv ***
// port assertions for the motion image readout block
`timescale 1ns/1ps
module omir_readout_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic spi_ncs_n,
    input wire logic spi_sclk,
    input wire logic spi_miso,
    input wire omir_pkg::omir_pixel_t pixel_in,
    input wire logic pixel_in_valid,
    input wire logic pixel_in_ready,
    input wire logic [15:0] exposure_time
);
    import omir_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // helper ages, saturating so long idle spans never wrap
    // ------------------------------------------------------------
    logic sclk_d;
    logic [15:0] exp_d;
    logic [7:0] fall_age;
    logic [7:0] end_age;
    logic [1:0] steps;
    logic frame_end;
    assign frame_end = pixel_in_valid && pixel_in_ready && pixel_in.last;
    // ages since last clock fall and frame end
    always_ff @(posedge core_clk) begin
        sclk_d <= spi_sclk;
        exp_d <= exposure_time;
        if (!rst_n) begin
            fall_age <= 8'hFF;
            end_age <= 8'hFF;
            steps <= 2'h0;
        end else begin
            fall_age <= (sclk_d && !spi_sclk) ? 8'h00 : fall_age + {7'h00, fall_age != 8'hFF};
            end_age <= frame_end ? 8'h00 : end_age + {7'h00, end_age != 8'hFF};
            steps <= frame_end ? 2'h0 : steps + {1'b0, exposure_time != exp_d && steps != 2'h3};
        end
    end
    sequence s_frame_end;
        frame_end;
    endsequence
    sequence s_exp_move;
        $changed(exposure_time);
    endsequence
    chk_miso_idle_low: assert property (spi_ncs_n && $past(spi_ncs_n) |-> !spi_miso)
        else $error("data out not low while deselected");
    chk_miso_after_fall: assert property ($changed(spi_miso) && !spi_ncs_n && $past(!spi_ncs_n) |-> fall_age <= 8'h03)
        else $error("data out moved away from a clock fall");
    chk_exp_reset_value: assert property ($rose(rst_n) |-> exposure_time == OMIR_RST_EXPOSURE)
        else $error("exposure not at reset value");
    chk_exp_never_zero: assert property (exposure_time >= OMIR_EXP_MIN)
        else $error("exposure below minimum");
    chk_exp_step_size: assert property (s_exp_move |-> (exposure_time > $past(exposure_time) ? exposure_time - $past(exposure_time) : $past(exposure_time) - exposure_time) <= ($past(exposure_time) >> 4) + 16'h0001)
        else $error("exposure step too large");
    chk_exp_after_frame: assert property (s_exp_move |-> end_age <= 8'd64)
        else $error("exposure moved without a frame end");
    chk_one_step_frame: assert property (steps <= 2'h1)
        else $error("exposure moved twice in one frame");
    chk_ready_recovers: assert property (!pixel_in_ready |-> ##[1:64] pixel_in_ready)
        else $error("pixel input refused too long");
    cov_frame_end: cover property (s_frame_end);
endmodule

bind omir_readout omir_readout_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .spi_ncs_n(spi_ncs_n),
    .spi_sclk(spi_sclk), .spi_miso(spi_miso), .pixel_in(pixel_in), .pixel_in_valid(pixel_in_valid),
    .pixel_in_ready(pixel_in_ready), .exposure_time(exposure_time));

// *** omir_spi_host.sv ***
// serial host model driving the four-wire port
`timescale 1ns/1ps
module omir_spi_host (
    input wire logic core_clk,
    output logic spi_ncs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso
);
    localparam int HALF = 4;
    // idle: deselected, clock parked high
    initial begin
        spi_ncs_n = 1'b1;
        spi_sclk = 1'b1;
        spi_mosi = 1'b0;
    end
    // move just after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // command byte then data byte, msb first, sampled at each rise
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {cmd, wdat};
        rdat = 8'h00;
        tick(1);
        spi_ncs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            tick(HALF);
            spi_sclk = 1'b0;
            spi_mosi = sh[i];
            tick(HALF);
            spi_sclk = 1'b1;
            if (i < 8) rdat[i] = spi_miso;
        end
        tick(HALF);
        spi_ncs_n = 1'b1;
        spi_mosi = ~spi_mosi; // released line must not look like held data
        tick(HALF);
    endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the motion image readout block
`timescale 1ns/1ps
module tb_top;
    import omir_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic spi_ncs_n, spi_sclk, spi_mosi, spi_miso, pixel_in_ready;
    omir_pixel_t pixel_in = '0;
    logic pixel_in_valid = 1'b0;
    omir_motion_t motion_in = '0;
    logic motion_valid = 1'b0;
    logic [2:0] resolution_sel = OMIR_RES_FULL;
    logic wide_motion = 1'b0;
    logic [15:0] exposure_time;
    logic [15:0] exp_model = OMIR_RST_EXPOSURE;
    logic [7:0] rd;
    int mismatches = 0;
    int total_checks = 0;
    always #50 core_clk = ~core_clk;
    omir_readout dut (.core_clk(core_clk), .rst_n(rst_n), .spi_ncs_n(spi_ncs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .pixel_in(pixel_in), .pixel_in_valid(pixel_in_valid),
        .pixel_in_ready(pixel_in_ready), .motion_in(motion_in), .motion_valid(motion_valid),
        .resolution_sel(resolution_sel), .wide_motion(wide_motion), .exposure_time(exposure_time));
    omir_spi_host host (.core_clk(core_clk), .spi_ncs_n(spi_ncs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] want, input string msg);
        total_checks++;
        if (got !== want) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, want);
        end
    endtask
    task automatic rreg(input logic [6:0] a, input logic [7:0] want, input string msg);
        host.xfer({1'b0, a}, 8'h00, rd);
        check({8'h00, rd}, {8'h00, want}, msg);
    endtask
    task automatic motion(input logic [11:0] dx, input logic [11:0] dy);
        motion_in = '{dx: dx, dy: dy};
        motion_valid = 1'b1;
        @(posedge core_clk);
        #1;
        motion_valid = 1'b0;
    endtask
    // one frame; kind 1 saturates all stats
    task automatic run_frame(input bit kind);
        logic [7:0] v, pk, lo;
        int sum, feat;
        bit taken;
        pk = 8'h00;
        lo = 8'hFF;
        sum = 0;
        feat = 0;
        for (int i = 0; i < 484; i++) begin
            v = (kind || i == 7) ? 8'hFF : 8'(20 + 3 * (i % 60));
            pixel_in = '{last: i == 483, feature: kind || i % 3 == 0, value: v};
            pixel_in_valid = 1'b1;
            v = (v > OMIR_PIXEL_MAX) ? OMIR_PIXEL_MAX : v;
            pk = (v > pk) ? v : pk;
            lo = (v < lo) ? v : lo;
            sum += v;
            feat += int'(pixel_in.feature);
            taken = 1'b0;
            while (!taken) begin
                taken = (pixel_in_ready === 1'b1);
                @(posedge core_clk);
                #1;
            end
        end
        pixel_in_valid = 1'b0;
        exp_model = (pk > OMIR_EXP_PEAK_HIGH) ? exp_model - (exp_model >> 4) - 16'h1 : exp_model;
        for (int k = 0; k < 100 && exposure_time !== exp_model; k++) @(posedge core_clk);
        #1;
        check(exposure_time, exp_model, "exposure port");
        rreg(OMIR_ADDR_PEAK, pk, "peak pixel");
        rreg(OMIR_ADDR_LOWEST, lo, "lowest pixel");
        rreg(OMIR_ADDR_SUM, 8'(((sum > 122936) ? 122936 : sum) >> 9), "pixel sum");
        rreg(OMIR_ADDR_QUALITY, 8'(((feat > 360) ? 360 : feat) / 2), "quality");
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        logic [7:0] rv [10];
        rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'hD0, 8'h80, 8'h00, 8'h00, 8'h00};
        for (int a = 0; a < 10; a++) rreg(7'(a + 3), rv[a], "reset value");
        host.xfer(8'h85, 8'h77, rd);
        rreg(OMIR_ADDR_QUALITY, 8'h00, "read-only write ignored");
        rreg(7'h20, 8'h00, "unmapped read");
    endtask
    task automatic test_motion();
        motion(12'h005, 12'hFFD);
        motion(12'h002, 12'h000);
        rreg(OMIR_ADDR_HORIZ, 8'h07, "x accumulated");
        rreg(OMIR_ADDR_HORIZ, 8'h00, "x cleared by read");
        rreg(OMIR_ADDR_VERT, 8'hFD, "y negative");
        rreg(OMIR_ADDR_VERT, 8'h00, "y cleared by read");
        resolution_sel = 3'h1;
        motion(12'h014, 12'h000);
        rreg(OMIR_ADDR_HORIZ, 8'h05, "x scaled");
        resolution_sel = OMIR_RES_FULL;
        motion(12'h12C, 12'h000);
        rreg(OMIR_ADDR_HORIZ, 8'h7F, "x narrow saturation");
        wide_motion = 1'b1;
        motion(12'h123, 12'hE00);
        rreg(OMIR_ADDR_HORIZ, 8'h23, "wide x low");
        rreg(OMIR_ADDR_VERT, 8'h00, "wide y low");
        rreg(OMIR_ADDR_UPPER, 8'h1E, "wide upper bits");
        wide_motion = 1'b0;
    endtask
    task automatic test_frames();
        run_frame(1'b0);
        rreg(OMIR_ADDR_EXP_HIGH, exp_model[15:8], "exposure high");
        rreg(OMIR_ADDR_EXP_LOW, exp_model[7:0], "exposure low");
        rreg(OMIR_ADDR_CAPTURE, 8'h8A, "grab pixel 0");
        host.xfer({1'b0, OMIR_ADDR_CAPTURE}, 8'h00, rd);
        check({15'h0, rd[7]}, 16'h0, "grab flag cleared");
        run_frame(1'b0);
        rreg(OMIR_ADDR_CAPTURE, 8'h8B, "grab pixel 1");
        host.xfer({1'b1, OMIR_ADDR_CAPTURE}, 8'h5A, rd);
        host.xfer({1'b0, OMIR_ADDR_CAPTURE}, 8'h00, rd);
        check({15'h0, rd[7]}, 16'h0, "grab flag after write");
        run_frame(1'b0);
        rreg(OMIR_ADDR_CAPTURE, 8'h8A, "grab back at origin");
        run_frame(1'b1);
    endtask
    // ------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        test_reset_values();
        test_motion();
        test_frames();
        tally_and_finish();
    end
    // ~10k cycles expected; 40k means a hang
    initial begin
        #4000000;
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
